// ### hw/acs_clock_source.sv
// Clock source selection and modulator clock generation
`timescale 1ns/1ns
`include "acs_params.svh"
// Behaviour
// [RQ1] Grounded clock pin at reset: internal oscillator
// [RQ2] Toggling external clock switches source to external
// [RQ3] External choice sticks until reset
// [RQ4] Modulator rate 32 kHz to 512 kHz
// [RQ5] Divide by 128, 32, 16, 8 per rate
// [RQ6] Same ratios for internal or nominal external clock
// [RQ7] Divided clock feeds the delta-sigma modulator
// [RQ8] All timing scales with system clock; the edge gap timeout here counts mclk cycles instead
// [RQ9] Confirm several edges, switch without runt pulses
module acs_clock_source
	import acs_pkg::*;
#(
	parameter logic [3:0] EDGE_CONFIRM = `ACS_EDGE_CONFIRM
)
(
	mclk,
	resetn,
	clk_pin,
	int_osc_tick,
	data_rate,
	int_osc_enable,
	ext_clock_active,
	sys_tick,
	mod_clock_tick,
	mod_ratio
);
	input wire logic mclk;
	input wire logic resetn;
	input wire logic clk_pin;
	input wire logic int_osc_tick;
	input wire acs_rate_t data_rate;
	output logic int_osc_enable;
	output logic ext_clock_active;
	output logic sys_tick;
	output logic mod_clock_tick;
	output logic [7:0] mod_ratio;

	// =====================================================
	// Reset release
	// Assert is immediate; release waits two edges so no flop
	// sees the release close to its own clock edge
	logic rst_a_q;
	logic rst_n;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rst_a_q <= 1'b0;
		else
			rst_a_q <= 1'b1;
	end

	// Only this flop reads the first stage
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rst_n <= 1'b0;
		else
			rst_n <= rst_a_q;
	end

	// =====================================================
	// Rate decode
	// Last rate code of each divide band; codes above go to the top
	localparam acs_rate_t RATE_SLOW_END = 4'h2;
	localparam acs_rate_t RATE_MID_END = 4'h5;
	localparam acs_rate_t RATE_FAST_END = 4'h8;

	function automatic logic [7:0] ratio_of(input acs_rate_t r);
		if (r <= RATE_SLOW_END)
			ratio_of = `ACS_DIV_SLOW; // see [RQ5]
		else if (r <= RATE_MID_END)
			ratio_of = `ACS_DIV_MID; // see [RQ5]
		else if (r <= RATE_FAST_END)
			ratio_of = `ACS_DIV_FAST; // see [RQ5]
		else
			ratio_of = `ACS_DIV_TOP; // see [RQ5]
	endfunction

	// Source test used by the mux and the status flops
	// Illegal codes count as internal, the safe side
	function automatic logic src_is_ext(input acs_src_t s);
		src_is_ext = (s == ACS_SRC_EXT);
	endfunction

	// =====================================================
	// External clock detection
	logic pin_q;
	logic [3:0] edges_q;
	acs_src_t src_q;
	// Limitation: the pin is sampled by mclk, so an external clock
	// must stay well below half of mclk or edges are lost
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			pin_q <= 1'b0;
		else
			pin_q <= clk_pin;
	end

	// Edges must come back to back; a stray glitch ages out
	// A pin stuck high gives one edge at most, after reset, so it never selects
	logic [7:0] gap_q;
	logic gap_over;
	assign gap_over = (gap_q == `ACS_EDGE_GAP);
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			gap_q <= 8'h00;
		else if (clk_pin && !pin_q)
			gap_q <= 8'h00; // see [RQ9]
		else if (!gap_over)
			gap_q <= gap_q + 8'h01;
	end

	// Counts rising edges; one edge alone may be noise
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			edges_q <= 4'h0;
		else if (src_q == ACS_SRC_INT && clk_pin && !pin_q)
			edges_q <= edges_q + 4'h1; // see [RQ9]
		else if (gap_over)
			edges_q <= 4'h0;
	end

	// Only reset returns the source to internal
	acs_src_t src_d;
	always_comb
	begin
		src_d = src_q;
		unique case (src_q)
			ACS_SRC_INT:
				if (edges_q >= EDGE_CONFIRM)
					src_d = ACS_SRC_EXT; // see [RQ2]
			ACS_SRC_EXT:
				src_d = ACS_SRC_EXT; // see [RQ3]
			default:
				src_d = ACS_SRC_INT;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			src_q <= ACS_SRC_INT; // see [RQ1]
		else
			src_q <= src_d;
	end

	// =====================================================
	// Source mux; switch happens between ticks, never mid pulse
	logic ext_tick;
	logic tick_d;
	assign ext_tick = clk_pin && !pin_q;
	always_comb
	begin
		if (src_is_ext(src_q))
			tick_d = ext_tick; // see [RQ9]
		else
			tick_d = int_osc_tick; // see [RQ2]
	end

	// =====================================================
	// System tick
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			sys_tick <= 1'b0;
		else
			sys_tick <= tick_d; // see [RQ8]
	end

	// =====================================================
	// Source status
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			int_osc_enable <= 1'b1;
		else
			int_osc_enable <= !src_is_ext(src_q); // see [RQ2]
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ext_clock_active <= 1'b0;
		else
			ext_clock_active <= src_is_ext(src_q); // see [RQ3]
	end

	// =====================================================
	// Ratio follows the rate code one cycle later
	// The divider takes a change only at its next wrap
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			mod_ratio <= `ACS_DIV_SLOW;
		else
			mod_ratio <= ratio_of(data_rate); // see [RQ6]
	end

	// =====================================================
	// Modulator clock; rate-selected ratio of the system tick
	// Divider resets with the block so both start in step
	acs_mod_div u_div
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.tick(sys_tick),
		.ratio(mod_ratio),
		.mod_tick(mod_clock_tick) // see [RQ4] see [RQ7]
	);
endmodule

// ### hw/acs_mod_div.sv
// Modulator clock divider driven by the selected system clock ticks
`timescale 1ns/1ns
`include "acs_params.svh"
module acs_mod_div
	import acs_pkg::*;
(
	mclk,
	rst_n,
	tick,
	ratio,
	mod_tick
);
	input wire logic mclk;
	input wire logic rst_n;
	input wire logic tick;
	input wire logic [7:0] ratio;
	output logic mod_tick;

	logic [7:0] cnt_q;
	logic [7:0] ratio_q;
	logic wrap;

	assign wrap = (cnt_q + 8'h01 >= ratio_q);

	// Ratio is only taken at wrap so no runt period appears
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ratio_q <= `ACS_DIV_SLOW;
		else if (tick && wrap)
			ratio_q <= ratio; // see [RQ9]
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 8'h00;
		else if (tick)
			cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			mod_tick <= 1'b0;
		else
			mod_tick <= tick && wrap;
	end
endmodule

// ### hw/acs_params.svh
// Constants for the clock source and modulator divider block
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_DIV_SLOW 8'h80
`define ACS_DIV_MID 8'h20
`define ACS_DIV_FAST 8'h10
`define ACS_DIV_TOP 8'h08
`define ACS_EDGE_CONFIRM 4'h4
`define ACS_EDGE_GAP 8'hFF
`define ACS_SYS_CLOCK_KHZ 16'h1000
`define ACS_MOD_MIN_KHZ 16'h0020
`define ACS_MOD_MAX_KHZ 16'h0200
`endif

// ### hw/acs_pkg.sv
// Types shared by the clock source block
package acs_pkg;
	typedef enum logic [1:0] {
		ACS_SRC_INT = 2'b01,
		ACS_SRC_EXT = 2'b10
	} acs_src_t;
	typedef logic [3:0] acs_rate_t;
endpackage

// ### testbench/acs_clock_source_props.sv
// Port checker for the clock source block
`timescale 1ns/1ns
module acs_clock_source_props
	import acs_pkg::*;
(
	input wire logic mclk, resetn, clk_pin, int_osc_tick,
	input wire acs_rate_t data_rate,
	input wire logic int_osc_enable, ext_clock_active,
	input wire logic sys_tick, mod_clock_tick,
	input wire logic [7:0] mod_ratio
);
	// ====
	// Source, tick and ratio checks
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	src_excl_a:
		assert property (int_osc_enable != ext_clock_active) else $error("src");
	ext_hold_a:
		assert property (ext_clock_active |=> ext_clock_active) else $error("hold");
	int_tick_a:
		assert property ($past(resetn, 3) && int_osc_enable && int_osc_tick
			|=> sys_tick || ext_clock_active) else $error("int");
	ext_tick_a:
		assert property (ext_clock_active && $rose(clk_pin) |=> sys_tick)
			else $error("ext");
	ext_quiet_a:
		assert property (ext_clock_active && !$rose(clk_pin) |=> !sys_tick)
			else $error("quiet");
	mod_pair_a:
		assert property (mod_clock_tick |-> $past(sys_tick)) else $error("pair");
	mod_gap_a:
		assert property (mod_clock_tick |=> !mod_clock_tick [*7])
			else $error("runt");
	ratio_top_a:
		assert property ($past(resetn, 3) && data_rate > 4'h8
			&& $stable(data_rate) |=> mod_ratio == 8'h08) else $error("ratio");
endmodule

// ### testbench/acs_clock_source_tb.sv
// Self-checking bench for the clock source block
`timescale 1ns/1ns
module acs_clock_source_tb;
	import acs_pkg::*;
	logic mclk = 1'h0, resetn = 1'h0, int_osc_tick = 1'h0, en = 1'h0;
	logic clk_pin, int_osc_enable, ext_clock_active, sys_tick, mod_clock_tick;
	logic [7:0] mod_ratio, n;
	logic [1:0] t = 2'h0;
	acs_rate_t data_rate = 4'h0;
	int mismatches = 0, total_checks = 0;
	acs_clock_source u_dut(.*);
	acs_ext_osc u_osc(.*);
	// ====
	// Stimulus and checks
	initial forever #2 mclk = ~mclk;
	always @(posedge mclk) {int_osc_tick, t} <= #1 {&t, t + 2'h1};
	task chk(string s, logic [7:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask
	task per;
		n = 8'h0;
		@(negedge mclk iff mod_clock_tick);
		do @(negedge mclk) n += sys_tick; while (!mod_clock_tick);
	endtask
	task rst;
		@(posedge mclk) #1 resetn = 1'h0;
		repeat (4) @(posedge mclk);
		#1 resetn = 1'h1;
		repeat (3) @(negedge mclk);
		chk("int", 8'h1, int_osc_enable);
	endtask
	task t_int;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge mclk) #1 data_rate = 4'(i * 3);
			per;
			per;
			chk("period", 8'h80 >> (i + (i > 0)), n);
			chk("ratio", 8'h80 >> (i + (i > 0)), mod_ratio);
		end
		$display("rates done");
	endtask
	task t_ext;
		@(posedge mclk) #1 en = 1'h1;
		@(negedge mclk iff ext_clock_active);
		per;
		per;
		chk("ext period", 8'h8, n);
		chk("osc off", 8'h0, int_osc_enable);
		@(posedge mclk) #1 en = 1'h0;
		data_rate = 4'h0;
		repeat (99) @(negedge mclk);
		n = 8'h0;
		repeat (400) @(negedge mclk) n += sys_tick;
		chk("idle", 8'h0, n);
		chk("hold", 8'h1, ext_clock_active);
		$display("ext done");
	endtask
	initial
	begin
		rst;
		t_int;
		t_ext;
		rst;
		end_sim;
	end
	initial
	begin
		#90000;
		mismatches++;
		end_sim;
	end
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
endmodule
bind acs_clock_source acs_clock_source_props u_props(.*);

// ### testbench/acs_ext_osc.sv
// External oscillator model on the clock pin
`timescale 1ns/1ns
module acs_ext_osc
(
	input wire logic en,
	output logic clk_pin = 1'h0
);
	// ====
	// Grounded when idle; odd phase keeps edges off mclk
	initial #1 forever #122 clk_pin = en & ~clk_pin;
endmodule
